// File: verilog/bec_exec_unit.sv
// Execution unit for jumps, calls, returns, compares, skips, branches and bit ops
`timescale 1ns/10ps
`include "bec_map.svh"

module bec_exec_unit #(
    parameter int PC_W = 10
) (
    input wire logic clock_i,                     // Core clock, 125 MHz
    input wire logic nrst_i,                      // Asynchronous reset, active low
    input wire logic cmd_valid_i,                 // Instruction offered
    output logic cmd_ready_o,                     // Unit idle, instruction taken
    input wire bec_pkg::bec_cmd_s cmd_i,          // Decoded instruction and operands
    input wire logic [PC_W-1:0] z_ptr_i,          // Z pointer word address
    input wire logic [PC_W-1:0] stack_data_i,     // Return address on top of stack
    output logic [PC_W-1:0] pc_o,                 // Program counter
    output logic [7:0] status_flag_register_o,                    // Status flags
    output bec_pkg::bec_wb_s wb_o,                // Write-back strobes and data
    output logic [PC_W-1:0] push_addr_o,          // Return address for a push
    output logic done_o                           // Instruction finished
);
    import bec_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    bec_state_e state_ff;
    logic [2:0] cnt_ff;
    logic [PC_W-1:0] pc_ff;
    logic [7:0] status_flag_register_ff;
    logic [PC_W-1:0] pend_pc_ff;
    logic [7:0] pend_status_flag_register_ff;
    bec_wb_s pend_wb_ff;
    logic [PC_W-1:0] push_addr_ff;
    bec_wb_s wb_ff;
    logic done_ff;

    logic accept;
    logic commit;
    logic [PC_W-1:0] nxt_pc;
    logic [7:0] nxt_status_flag_register;
    bec_wb_s nxt_wb;
    logic [2:0] nxt_cyc;

    logic [PC_W-1:0] pc_inc;
    logic [PC_W-1:0] pc_rel;
    logic [7:0] cmp_src;
    logic cmp_cin;
    logic [8:0] cmp_full;
    logic [7:0] cmp_diff;
    logic cmp_h;
    logic cmp_v;
    logic [7:0] sum_inc;
    logic [7:0] sum_dec;
    logic skip_hit;
    logic br_is;
    logic br_flag;
    logic br_want;
    logic br_taken;

    assign cmd_ready_o = (state_ff == ST_IDLE);
    assign accept = cmd_valid_i & cmd_ready_o;
    assign commit = (accept && nxt_cyc == `BEC_CYC_SINGLE)
        || (state_ff == ST_BUSY && cnt_ff == `BEC_CYC_SINGLE);

    assign pc_o = pc_ff;
    assign status_flag_register_o = status_flag_register_ff;
    assign wb_o = wb_ff;
    assign push_addr_o = push_addr_ff;
    assign done_o = done_ff;

    // ************************************************************
    // Flag helpers
    // ************************************************************
    // S tracks N xor V so later signed tests stay consistent
    function automatic logic [7:0] znv(input logic [7:0] f, input logic [7:0] r,
                                       input logic v);
        logic [7:0] o;
        o = f;
        o[`BEC_FZ] = (r == `BEC_ZERO);
        o[`BEC_FN] = r[`BEC_MSB];
        o[`BEC_FV] = v;
        o[`BEC_FS] = r[`BEC_MSB] ^ v;
        return o;
    endfunction

    // Shift results: V is N xor the new carry
    function automatic logic [7:0] shc(input logic [7:0] f, input logic [7:0] r,
                                       input logic c);
        logic [7:0] o;
        o = znv(f, r, r[`BEC_MSB] ^ c);
        o[`BEC_FC] = c;
        return o;
    endfunction

    // ************************************************************
    // Datapath
    // ************************************************************
    assign pc_inc = pc_ff + PC_W'(1);
    assign pc_rel = pc_ff + PC_W'($signed(cmd_i.offset)) + PC_W'(1);
    assign sum_inc = cmd_i.rd_val + 8'h01;
    assign sum_dec = cmd_i.rd_val - 8'h01;

    assign cmp_src = (cmd_i.op == OP_COMPARE_IMMEDIATE) ? cmd_i.imm : cmd_i.rr_val;
    assign cmp_cin = (cmd_i.op == OP_COMPARE_WITH_CARRY) & status_flag_register_ff[`BEC_FC];
    assign cmp_full = {1'h0, cmd_i.rd_val} - {1'h0, cmp_src} - {8'h00, cmp_cin};
    assign cmp_diff = cmp_full[7:0];
    assign cmp_h = (~cmd_i.rd_val[`BEC_NIB_MSB] & cmp_src[`BEC_NIB_MSB])
        | (cmp_src[`BEC_NIB_MSB] & cmp_diff[`BEC_NIB_MSB])
        | (cmp_diff[`BEC_NIB_MSB] & ~cmd_i.rd_val[`BEC_NIB_MSB]);
    assign cmp_v = (cmd_i.rd_val[`BEC_MSB] & ~cmp_src[`BEC_MSB] & ~cmp_diff[`BEC_MSB])
        | (~cmd_i.rd_val[`BEC_MSB] & cmp_src[`BEC_MSB] & cmp_diff[`BEC_MSB]);

    // Skip conditions for register, I/O and equality skips
    always_comb begin
        case (cmd_i.op)
            OP_COMPARE_SKIP_EQUAL: skip_hit = (cmd_i.rd_val == cmd_i.rr_val);
            OP_SKIP_REG_BIT_CLEAR: skip_hit = ~cmd_i.rr_val[cmd_i.bit_sel];
            OP_SKIP_REG_BIT_SET: skip_hit = cmd_i.rr_val[cmd_i.bit_sel];
            OP_SKIP_IO_BIT_CLEAR: skip_hit = ~cmd_i.io_val[cmd_i.bit_sel];
            OP_SKIP_IO_BIT_SET: skip_hit = cmd_i.io_val[cmd_i.bit_sel];
            default: skip_hit = 1'h0;
        endcase
    end

    // Branch flag select and polarity
    always_comb begin
        br_is = 1'h1;
        br_flag = status_flag_register_ff[cmd_i.flag_sel];
        br_want = 1'h1;
        case (cmd_i.op)
            OP_BRANCH_FLAG_SET: br_want = 1'h1;
            OP_BRANCH_FLAG_CLEAR: br_want = 1'h0;
            OP_BRANCH_EQUAL: br_flag = status_flag_register_ff[`BEC_FZ];
            OP_BRANCH_NOT_EQUAL: begin
                br_flag = status_flag_register_ff[`BEC_FZ];
                br_want = 1'h0;
            end
            OP_BRANCH_CARRY_SET, OP_BRANCH_LOWER: br_flag = status_flag_register_ff[`BEC_FC];
            OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_HIGHER: begin
                br_flag = status_flag_register_ff[`BEC_FC];
                br_want = 1'h0;
            end
            OP_BRANCH_MINUS: br_flag = status_flag_register_ff[`BEC_FN];
            OP_BRANCH_PLUS: begin
                br_flag = status_flag_register_ff[`BEC_FN];
                br_want = 1'h0;
            end
            // N xor V is used rather than the stored S, which other units may leave stale
            OP_BRANCH_SIGNED_GE: begin
                br_flag = status_flag_register_ff[`BEC_FN] ^ status_flag_register_ff[`BEC_FV];
                br_want = 1'h0;
            end
            OP_BRANCH_SIGNED_LT: br_flag = status_flag_register_ff[`BEC_FN] ^ status_flag_register_ff[`BEC_FV];
            OP_BRANCH_HALF_SET: br_flag = status_flag_register_ff[`BEC_FH];
            OP_BRANCH_HALF_CLEAR: begin
                br_flag = status_flag_register_ff[`BEC_FH];
                br_want = 1'h0;
            end
            OP_BRANCH_TRANSFER_SET: br_flag = status_flag_register_ff[`BEC_FT];
            OP_BRANCH_TRANSFER_CLEAR: begin
                br_flag = status_flag_register_ff[`BEC_FT];
                br_want = 1'h0;
            end
            OP_BRANCH_OVERFLOW_SET: br_flag = status_flag_register_ff[`BEC_FV];
            OP_BRANCH_OVERFLOW_CLEAR: begin
                br_flag = status_flag_register_ff[`BEC_FV];
                br_want = 1'h0;
            end
            OP_BRANCH_IRQ_ENABLED: br_flag = status_flag_register_ff[`BEC_FI];
            OP_BRANCH_IRQ_DISABLED: begin
                br_flag = status_flag_register_ff[`BEC_FI];
                br_want = 1'h0;
            end
            default: br_is = 1'h0;
        endcase
    end
    assign br_taken = br_is & (br_flag == br_want);

    // ************************************************************
    // Instruction results
    // ************************************************************
    always_comb begin
        nxt_pc = pc_inc;
        nxt_status_flag_register = status_flag_register_ff;
        nxt_wb = '0;
        nxt_cyc = `BEC_CYC_SINGLE;
        case (cmd_i.op)
            OP_INC: begin
                nxt_wb.reg_we = 1'h1;
                nxt_wb.reg_val = sum_inc;
                nxt_status_flag_register = znv(status_flag_register_ff, sum_inc, cmd_i.rd_val == `BEC_MAX_POS);
            end
            OP_DEC: begin
                nxt_wb.reg_we = 1'h1;
                nxt_wb.reg_val = sum_dec;
                nxt_status_flag_register = znv(status_flag_register_ff, sum_dec, cmd_i.rd_val == `BEC_MIN_NEG);
            end
            OP_ZERO_MINUS_TEST: nxt_status_flag_register = znv(status_flag_register_ff, cmd_i.rd_val, 1'h0);
            OP_CLEAR_REGISTER: begin
                nxt_wb.reg_we = 1'h1;
                nxt_wb.reg_val = `BEC_ZERO;
                nxt_status_flag_register = znv(status_flag_register_ff, `BEC_ZERO, 1'h0);
            end
            OP_SET_ALL_ONES: begin
                nxt_wb.reg_we = 1'h1;
                nxt_wb.reg_val = `BEC_ONES;
            end
            OP_RELATIVE_JUMP: begin
                nxt_pc = pc_rel;
                nxt_cyc = `BEC_CYC_JUMP;
            end
            OP_POINTER_JUMP: begin
                nxt_pc = z_ptr_i;
                nxt_cyc = `BEC_CYC_JUMP;
            end
            OP_RELATIVE_CALL: begin
                nxt_pc = pc_rel;
                nxt_wb.push = 1'h1;
                nxt_cyc = `BEC_CYC_CALL;
            end
            OP_POINTER_CALL: begin
                nxt_pc = z_ptr_i;
                nxt_wb.push = 1'h1;
                nxt_cyc = `BEC_CYC_CALL;
            end
            OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT: begin
                nxt_pc = stack_data_i;
                nxt_wb.pop = 1'h1;
                nxt_cyc = `BEC_CYC_RET;
                nxt_status_flag_register[`BEC_FI] = status_flag_register_ff[`BEC_FI]
                    | (cmd_i.op == OP_INTERRUPT_EXIT);
            end
            OP_COMPARE_REGS, OP_COMPARE_WITH_CARRY, OP_COMPARE_IMMEDIATE: begin
                nxt_status_flag_register = znv(status_flag_register_ff, cmp_diff, cmp_v);
                // Carry form keeps Z only while every byte so far was zero
                nxt_status_flag_register[`BEC_FZ] = (cmp_diff == `BEC_ZERO)
                    & ((cmd_i.op != OP_COMPARE_WITH_CARRY) | status_flag_register_ff[`BEC_FZ]);
                nxt_status_flag_register[`BEC_FC] = cmp_full[8];
                nxt_status_flag_register[`BEC_FH] = cmp_h;
            end
            OP_IO_BIT_FORCE_ONE, OP_IO_BIT_FORCE_ZERO: begin
                nxt_wb.io_we = 1'h1;
                nxt_wb.io_val = cmd_i.io_val;
                nxt_wb.io_val[cmd_i.bit_sel] = (cmd_i.op == OP_IO_BIT_FORCE_ONE);
                nxt_cyc = `BEC_CYC_IOBIT;
            end
            OP_SHIFT_LEFT_LOGICAL: begin
                nxt_wb.reg_we = 1'h1;
                nxt_wb.reg_val = {cmd_i.rd_val[6:0], 1'h0};
                nxt_status_flag_register = shc(status_flag_register_ff, nxt_wb.reg_val, cmd_i.rd_val[`BEC_MSB]);
            end
            OP_SHIFT_RIGHT_LOGICAL: begin
                nxt_wb.reg_we = 1'h1;
                nxt_wb.reg_val = {1'h0, cmd_i.rd_val[7:1]};
                nxt_status_flag_register = shc(status_flag_register_ff, nxt_wb.reg_val, cmd_i.rd_val[0]);
            end
            OP_ROTATE_LEFT_CARRY: begin
                nxt_wb.reg_we = 1'h1;
                nxt_wb.reg_val = {cmd_i.rd_val[6:0], status_flag_register_ff[`BEC_FC]};
                nxt_status_flag_register = shc(status_flag_register_ff, nxt_wb.reg_val, cmd_i.rd_val[`BEC_MSB]);
            end
            default: begin
                if (skip_hit) begin
                    nxt_pc = cmd_i.next_two_word ? pc_ff + PC_W'(`BEC_PC_SKIP2)
                        : pc_ff + PC_W'(`BEC_PC_SKIP1);
                    nxt_cyc = cmd_i.next_two_word ? `BEC_CYC_SKIP2 : `BEC_CYC_SKIP1;
                end else if (br_taken) begin
                    nxt_pc = pc_rel;
                    nxt_cyc = `BEC_CYC_TAKEN;
                end
            end
        endcase
    end

    // ************************************************************
    // Sequencing
    // ************************************************************
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_ff <= ST_IDLE;
            cnt_ff <= `BEC_CYC_SINGLE;
        end else if (accept && nxt_cyc != `BEC_CYC_SINGLE) begin
            state_ff <= ST_BUSY;
            cnt_ff <= nxt_cyc - `BEC_CYC_SINGLE;
        end else if (state_ff == ST_BUSY) begin
            cnt_ff <= cnt_ff - `BEC_CYC_SINGLE;
            if (cnt_ff == `BEC_CYC_SINGLE) begin
                state_ff <= ST_IDLE;
            end
        end
    end

    // Results held while a multi-cycle instruction runs
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pend_pc_ff <= `BEC_PC_RST;
            pend_status_flag_register_ff <= `BEC_STATUS_FLAG_REGISTER_RST;
            pend_wb_ff <= '0;
        end else if (accept) begin
            pend_pc_ff <= nxt_pc;
            pend_status_flag_register_ff <= nxt_status_flag_register;
            pend_wb_ff <= nxt_wb;
        end
    end

    // Architectural state only moves at the last cycle of an instruction
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pc_ff <= `BEC_PC_RST;
            status_flag_register_ff <= `BEC_STATUS_FLAG_REGISTER_RST;
        end else if (commit) begin
            pc_ff <= accept ? nxt_pc : pend_pc_ff;
            status_flag_register_ff <= accept ? nxt_status_flag_register : pend_status_flag_register_ff;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wb_ff <= '0;
            done_ff <= 1'h0;
            push_addr_ff <= `BEC_PC_RST;
        end else begin
            wb_ff <= commit ? (accept ? nxt_wb : pend_wb_ff) : '0;
            done_ff <= commit;
            if (accept) begin
                push_addr_ff <= pc_inc;
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    chk_dec_value: assert property (accept && cmd_i.op == OP_DEC |=> done_o && wb_o.reg_we
        && wb_o.reg_val == $past(cmd_i.rd_val) - 8'h01)
        else $error("decrement result wrong");
    chk_set_ones: assert property (accept && cmd_i.op == OP_SET_ALL_ONES |=> done_o
        && wb_o.reg_val == `BEC_ONES && status_flag_register_o == $past(status_flag_register_o))
        else $error("set-all-ones result or flags wrong");
    chk_jump_two: assert property (accept && cmd_i.op == OP_RELATIVE_JUMP |=> !done_o ##1
        (done_o && pc_o == $past(pc_o, 2) + PC_W'($signed($past(cmd_i.offset, 2)))
        + PC_W'(1)))
        else $error("relative jump target or timing wrong");
    chk_exit_four: assert property (accept && cmd_i.op == OP_SUBROUTINE_EXIT |=>
        !done_o [*3] ##1 (done_o && wb_o.pop && pc_o == $past(stack_data_i, 4)))
        else $error("subroutine exit wrong");
    chk_interrupt_exit_gie: assert property (accept && cmd_i.op == OP_INTERRUPT_EXIT
        |-> ##4 status_flag_register_o[`BEC_FI])
        else $error("interrupt exit did not set I");
    chk_compare_skip_equal_skip: assert property (accept && cmd_i.op == OP_COMPARE_SKIP_EQUAL
        && cmd_i.rd_val == cmd_i.rr_val && !cmd_i.next_two_word
        |=> !done_o ##1 (done_o && pc_o == $past(pc_o, 2) + PC_W'(`BEC_PC_SKIP1)))
        else $error("equal skip wrong");
    chk_cmp_nostore: assert property (accept && cmd_i.op == OP_COMPARE_REGS |=> !wb_o.reg_we
        && status_flag_register_o[`BEC_FZ] == ($past(cmd_i.rd_val) == $past(cmd_i.rr_val)))
        else $error("compare stored or Z wrong");
    chk_signed_ge: assert property (accept && cmd_i.op == OP_BRANCH_SIGNED_GE
        && (status_flag_register_o[`BEC_FN] ^ status_flag_register_o[`BEC_FV]) |=> done_o && pc_o == $past(pc_o) + PC_W'(1))
        else $error("signed ge taken wrongly");
    chk_io_force: assert property (accept && cmd_i.op == OP_IO_BIT_FORCE_ZERO |=> !done_o ##1
        (wb_o.io_we && !wb_o.io_val[$past(cmd_i.bit_sel, 2)]))
        else $error("io bit clear wrong");
    chk_rotate_carry: assert property (accept && cmd_i.op == OP_ROTATE_LEFT_CARRY |=>
        status_flag_register_o[`BEC_FC] == $past(cmd_i.rd_val[`BEC_MSB])
        && wb_o.reg_val[0] == $past(status_flag_register_o[`BEC_FC]))
        else $error("rotate through carry wrong");

    cov_branch_taken: cover property (accept && br_taken ##1 !done_o ##1 done_o);
    cov_call: cover property (accept && cmd_i.op == OP_RELATIVE_CALL ##3 wb_o.push);
    cov_skip_long: cover property (accept && skip_hit && cmd_i.next_two_word);
    cov_interrupt_exit: cover property (accept && cmd_i.op == OP_INTERRUPT_EXIT);

endmodule

// File: verilog/bec_map.svh
// Constant map for the branch, compare and bit execution unit
`ifndef BEC_MAP_SVH
`define BEC_MAP_SVH

// Reset values
`define BEC_PC_RST '0
`define BEC_STATUS_FLAG_REGISTER_RST 8'h00

// Status flag bit positions
`define BEC_FC 0
`define BEC_FZ 1
`define BEC_FN 2
`define BEC_FV 3
`define BEC_FS 4
`define BEC_FH 5
`define BEC_FT 6
`define BEC_FI 7

// Data constants
`define BEC_MSB 7
`define BEC_NIB_MSB 3
`define BEC_ZERO 8'h00
`define BEC_ONES 8'hFF
`define BEC_MAX_POS 8'h7F
`define BEC_MIN_NEG 8'h80

// Cycle counts
`define BEC_CYC_SINGLE 3'h1
`define BEC_CYC_JUMP 3'h2
`define BEC_CYC_CALL 3'h3
`define BEC_CYC_RET 3'h4
`define BEC_CYC_IOBIT 3'h2
`define BEC_CYC_TAKEN 3'h2
`define BEC_CYC_SKIP1 3'h2
`define BEC_CYC_SKIP2 3'h3

// Program counter steps for skips
`define BEC_PC_SKIP1 2
`define BEC_PC_SKIP2 3

`endif

// File: verilog/bec_pkg.sv
// Types shared by the branch, compare and bit execution unit
package bec_pkg;

    typedef enum logic [5:0] {
        OP_INC, OP_DEC, OP_ZERO_MINUS_TEST, OP_CLEAR_REGISTER, OP_SET_ALL_ONES,
        OP_RELATIVE_JUMP, OP_POINTER_JUMP, OP_RELATIVE_CALL, OP_POINTER_CALL,
        OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT, OP_COMPARE_SKIP_EQUAL,
        OP_COMPARE_REGS, OP_COMPARE_WITH_CARRY, OP_COMPARE_IMMEDIATE,
        OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET,
        OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR, OP_BRANCH_EQUAL, OP_BRANCH_NOT_EQUAL,
        OP_BRANCH_CARRY_SET, OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_HIGHER, OP_BRANCH_LOWER,
        OP_BRANCH_MINUS, OP_BRANCH_PLUS, OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT,
        OP_BRANCH_HALF_SET, OP_BRANCH_HALF_CLEAR, OP_BRANCH_TRANSFER_SET,
        OP_BRANCH_TRANSFER_CLEAR, OP_BRANCH_OVERFLOW_SET, OP_BRANCH_OVERFLOW_CLEAR,
        OP_BRANCH_IRQ_ENABLED, OP_BRANCH_IRQ_DISABLED, OP_IO_BIT_FORCE_ONE,
        OP_IO_BIT_FORCE_ZERO, OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL,
        OP_ROTATE_LEFT_CARRY
    } bec_op_e;

    typedef enum {ST_IDLE, ST_BUSY} bec_state_e;

    typedef struct packed {
        bec_op_e op;
        logic [7:0] rd_val;
        logic [7:0] rr_val;
        logic [7:0] imm;
        logic [2:0] bit_sel;
        logic [2:0] flag_sel;
        logic [11:0] offset;
        logic [7:0] io_val;
        logic next_two_word;
    } bec_cmd_s;

    typedef struct packed {
        logic reg_we;
        logic [7:0] reg_val;
        logic io_we;
        logic [7:0] io_val;
        logic push;
        logic pop;
    } bec_wb_s;

endpackage

// File: test/tb_bec_exec_unit.sv
// Self-checking bench for the branch, compare and bit execution unit
`timescale 1ns/10ps
module tb_bec_exec_unit;
    import bec_pkg::*;
    typedef struct {bec_op_e op; logic [9:0] pc; logic [7:0] sr; bec_wb_s wb;
        int due;} bec_note_s;
    // ****************************************
    // Design and clock
    // ****************************************
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    logic cmd_valid_i = 1'b0;
    bec_cmd_s cmd_i = '0;
    logic [9:0] z_ptr_i = '0;
    logic [9:0] stack_data_i = '0;
    logic [9:0] pc_o, push_addr_o, pc_m = '0;
    logic [7:0] status_flag_register_o, status_flag_register_m = '0;
    logic cmd_ready_o, done_o;
    bec_wb_s wb_o;
    bec_note_s q[$];
    int fails = 0, checked = 0, cyc = 0, seed = 35;
    // Branch index into {N^V, flag_sel bit, flags}, and whether a set bit takes it
    int br_bit [20] = '{8, 8, 1, 1, 0, 0, 0, 0, 2, 2, 9, 9, 5, 5, 6, 6, 3, 3, 7, 7};
    bit br_pol [20] = '{1, 0, 1, 0, 1, 0, 0, 1, 1, 0, 0, 1, 1, 0, 1, 0, 1, 0, 1, 0};

    bec_exec_unit #(.PC_W(10)) i_dut (.clock_i(clock_i), .nrst_i(nrst_i),
        .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_i(cmd_i),
        .z_ptr_i(z_ptr_i), .stack_data_i(stack_data_i), .pc_o(pc_o), .status_flag_register_o(status_flag_register_o),
        .wb_o(wb_o), .push_addr_o(push_addr_o), .done_o(done_o));

    always #4 clock_i = ~clock_i;

    // Hang guard: the whole run needs well under 4000 cycles
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            fails++;
            results();
        end
    end
    // ****************************************
    // Checking
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge clock_i) begin
        bec_note_s n;
        if (nrst_i && done_o === 1'b1) begin
            n = q.pop_front();
            chk(cyc[15:0], n.due[15:0], "latency");
            chk(pc_o, n.pc, "pc");
            chk(status_flag_register_o, n.sr, "flags");
            // Test may or may not write its unchanged value back
            chk({wb_o.reg_we & (n.op != OP_ZERO_MINUS_TEST), wb_o.io_we, wb_o.push, wb_o.pop},
                {n.wb.reg_we, n.wb.io_we, n.wb.push, n.wb.pop}, "strobes");
            if (n.wb.reg_we)
                chk(wb_o.reg_val, n.wb.reg_val, "reg value");
            if (n.wb.io_we)
                chk(wb_o.io_val, n.wb.io_val, "io value");
            if (n.wb.push)
                chk(push_addr_o, pc_m_ret(n), "return");
        end
    end
    // ****************************************
    // Stimulus and reference model
    // ****************************************
    logic [9:0] ret_q[$];
    function automatic logic [9:0] pc_m_ret(input bec_note_s n);
        return ret_q.pop_front();
    endfunction

    task automatic issue(input bec_cmd_s c);
        bec_note_s n;
        logic [7:0] a, b, r, f;
        logic cy, hc, ov, ci, tk, sk;
        logic [1:0] u;
        logic [9:0] w;
        int lat;
        z_ptr_i = 10'($random(seed));
        stack_data_i = 10'($random(seed));
        n = '{op: c.op, pc: pc_m + 10'h1, sr: 8'h00, wb: '0, due: 0};
        {a, r, f, lat, u} = {c.rd_val, c.rd_val, status_flag_register_m, 32'd1, 2'h0};
        {cy, hc, ov, tk, sk} = 5'h0;
        w = {f[2] ^ f[3], f[c.flag_sel], f};
        case (c.op)
            OP_INC: {u, r, ov} = {2'h1, a + 8'h01, a == 8'h7F};
            OP_DEC: {u, r, ov} = {2'h1, a - 8'h01, a == 8'h80};
            OP_ZERO_MINUS_TEST: u = 2'h1;
            OP_CLEAR_REGISTER: {u, r} = {2'h1, 8'h00};
            OP_SET_ALL_ONES: r = 8'hFF;
            OP_COMPARE_REGS, OP_COMPARE_WITH_CARRY, OP_COMPARE_IMMEDIATE: begin
                b = (c.op == OP_COMPARE_IMMEDIATE) ? c.imm : c.rr_val;
                ci = (c.op == OP_COMPARE_WITH_CARRY) & status_flag_register_m[0];
                {cy, r} = {1'b0, a} - {1'b0, b} - {8'h00, ci};
                hc = {1'b0, a[3:0]} < ({1'b0, b[3:0]} + {4'h0, ci});
                ov = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
                u = 2'h3;
            end
            OP_SHIFT_LEFT_LOGICAL: {u, cy, r} = {2'h2, a, 1'b0};
            OP_SHIFT_RIGHT_LOGICAL: {u, r, cy} = {2'h2, 1'b0, a};
            OP_ROTATE_LEFT_CARRY: {u, cy, r} = {2'h2, a, status_flag_register_m[0]};
            OP_RELATIVE_JUMP: {n.pc, lat} = {pc_m + c.offset[9:0] + 10'h1, 32'd2};
            OP_POINTER_JUMP: {n.pc, lat} = {z_ptr_i, 32'd2};
            OP_RELATIVE_CALL: {n.pc, lat} = {pc_m + c.offset[9:0] + 10'h1, 32'd3};
            OP_POINTER_CALL: {n.pc, lat} = {z_ptr_i, 32'd3};
            OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT: begin
                {n.pc, lat, n.wb.pop} = {stack_data_i, 32'd4, 1'b1};
                f[7] = f[7] | (c.op == OP_INTERRUPT_EXIT);
            end
            OP_COMPARE_SKIP_EQUAL: sk = a == c.rr_val;
            OP_SKIP_REG_BIT_CLEAR: sk = !a[c.bit_sel];
            OP_SKIP_REG_BIT_SET: sk = a[c.bit_sel];
            OP_SKIP_IO_BIT_CLEAR: sk = !c.io_val[c.bit_sel];
            OP_SKIP_IO_BIT_SET: sk = c.io_val[c.bit_sel];
            OP_IO_BIT_FORCE_ONE, OP_IO_BIT_FORCE_ZERO: begin
                {n.wb.io_we, n.wb.io_val, lat} = {1'b1, c.io_val, 32'd2};
                n.wb.io_val[c.bit_sel] = c.op == OP_IO_BIT_FORCE_ONE;
            end
            default: tk = w[br_bit[c.op - OP_BRANCH_FLAG_SET]]
                == br_pol[c.op - OP_BRANCH_FLAG_SET];
        endcase
        if (tk)
            {n.pc, lat} = {pc_m + c.offset[9:0] + 10'h1, 32'd2};
        if (sk)
            {n.pc, lat} = {pc_m + (c.next_two_word ? 10'h3 : 10'h2), c.next_two_word ? 32'd3 : 32'd2};
        if (u == 2'h2)
            ov = r[7] ^ cy;
        if (u != 2'h0)
            f[4:1] = {r[7] ^ ov, ov, r[7], r == 8'h00};
        if (u[1])
            f[0] = cy;
        if (u == 2'h3)
            f[5] = hc;
        if (c.op == OP_COMPARE_WITH_CARRY)
            f[1] = f[1] & status_flag_register_m[1];
        n.wb.push = c.op inside {OP_RELATIVE_CALL, OP_POINTER_CALL};
        n.wb.reg_we = c.op inside {OP_INC, OP_DEC, OP_CLEAR_REGISTER, OP_SET_ALL_ONES,
            OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL, OP_ROTATE_LEFT_CARRY};
        n.wb.reg_val = r;
        if (n.wb.push)
            ret_q.push_back(pc_m + 10'h1);
        {n.sr, status_flag_register_m, pc_m} = {f, f, n.pc};
        cmd_i = c;
        cmd_valid_i = 1'b1;
        while (cmd_ready_o !== 1'b1) begin
            @(posedge clock_i);
            #1;
        end
        // The checker reads cyc before its own edge updates it, so accept-to-done is lat
        n.due = cyc + lat;
        q.push_back(n);
        @(posedge clock_i);
        #1;
    endtask

    initial begin
        bec_cmd_s c;
        logic [63:0] rv;
        logic [7:0] pick [4] = '{8'h00, 8'h7F, 8'h80, 8'hFF};
        repeat (6) @(posedge clock_i);
        #1;
        nrst_i = 1'b1;
        chk(pc_o, 16'h0, "reset pc");
        chk(status_flag_register_o, 16'h0, "reset flags");
        // First pass walks every opcode in order, then random ones with corner operands
        for (int i = 0; i < 700; i++) begin
            rv = {$random(seed), $random(seed)};
            c = rv[56:0];
            c.op = bec_op_e'((i < 44) ? i[5:0] : rv[63:58] % 6'd44);
            if (i[0])
                c.rd_val = pick[i[2:1]];
            if (i[3] || c.op inside {OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET})
                c.rr_val = c.rd_val;
            issue(c);
        end
        cmd_valid_i = 1'b0;
        repeat (6) @(posedge clock_i);
        chk(q.size(), 16'h0, "pending results");
        results();
    end
endmodule
